// File: hw/gfe_consts.svh
/*
 * offsets, field positions, reset values and widths of the group frame
 * event control block.
 * assumes: included by bare name from the package and the design module.
 */
`ifndef GFE_CONSTS_SVH
`define GFE_CONSTS_SVH

// bus geometry
`define GFE_ADDR_W 8
`define GFE_RESP_OKAY 2'h0
`define GFE_RESP_SLVERR 2'h2

// register byte offsets
`define GFE_OFF_CFG 8'h00
`define GFE_OFF_MSGCFG 8'h04
`define GFE_OFF_STAT 8'h08
`define GFE_OFF_CLR 8'h0C
`define GFE_OFF_IEN 8'h10
`define GFE_OFF_TRANSP 8'h14
`define GFE_OFF_ACTIVE 8'h18

// group configuration bit positions
`define GFE_CFG_COPY_BIT 6
`define GFE_CFG_RMASK_BIT 5
`define GFE_CFG_LMASK_BIT 4
`define GFE_CFG_ABORT_BIT 3

// group configuration reset values
`define GFE_RST_COPY 1'h1
`define GFE_RST_RMASK 1'h0
`define GFE_RST_LMASK 1'h0
`define GFE_RST_ABORT 1'h0

// message configuration word layout
`define GFE_MSGCFG_W 8
`define GFE_MSGCFG_PEND_LSB 8
`define GFE_MSGCFG_PVAL_BIT 16
`define GFE_RST_MSGCFG 8'h00

// status / clear / enable bit positions
`define GFE_STAT_W 4
`define GFE_ST_REALIGN 0
`define GFE_ST_LOSS 1
`define GFE_ST_RECOVER 2
`define GFE_ST_RXERR 3
`define GFE_RST_IEN 4'h0

// channel group
`define GFE_NCHAN 32
`define GFE_CHAN_W 5
`define GFE_RST_TRANSP 32'h00000000
`define GFE_RST_ACTIVE 32'h00000000

`endif

// File: hw/gfe_pkg.sv
/*
 * types of the group frame event control block.
 * assumes: gfe_consts.svh on the include path.
 */
`include "gfe_consts.svh"

package gfe_pkg;

    // axi4-lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [`GFE_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`GFE_ADDR_W-1:0] araddr;
        logic rready;
    } gfe_axi_req_type;

    // axi4-lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gfe_axi_resp_type;

    // receive error codes, as reported by the receiver and in status
    typedef enum logic [2:0] {
        ERR_NONE, ERR_ABORT, ERR_CHECKSUM, ERR_LENGTH, ERR_ALIGN,
        ERR_FRAME_LOSS
    } gfe_rx_err_type;

    // interrupt descriptor event kinds
    typedef enum logic [1:0] {
        EVT_REALIGN, EVT_FRAME_LOSS, EVT_FRAME_RECOVERY, EVT_RX_ERROR
    } gfe_evt_type;

    // end of a received message from the receiver
    typedef struct packed {
        logic valid;
        logic [`GFE_CHAN_W-1:0] chan;
        gfe_rx_err_type code;
    } gfe_rx_end_type;

    // interrupt descriptor
    typedef struct packed {
        logic valid;
        gfe_evt_type evt;
        gfe_rx_err_type err;
        logic [`GFE_CHAN_W-1:0] chan;
    } gfe_int_desc_type;

    // transmit buffer descriptor as fetched
    typedef struct packed {
        logic valid;
        logic endOfMessageFlag;
        logic [`GFE_MSGCFG_W-1:0] msgCfg;
    } gfe_tx_desc_type;

    // whole state of the block
    typedef struct packed {
        logic awRdy;
        logic wRdy;
        logic awFull;
        logic wFull;
        logic [`GFE_ADDR_W-1:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic msgCfgCopyEnable;
        logic frameRealignIrqMask;
        logic frameLossIrqMask;
        logic frameLossAbortEnable;
        logic [`GFE_MSGCFG_W-1:0] msgCfg;
        logic [`GFE_MSGCFG_W-1:0] pendCfg;
        logic pendValid;
        logic [`GFE_STAT_W-1:0] stat;
        logic [`GFE_STAT_W-1:0] irqEn;
        logic irq;
        logic [`GFE_NCHAN-1:0] chanTransp;
        logic [`GFE_NCHAN-1:0] chanActive;
        logic lossSeen;
        logic rxSuspend;
        logic rxAbortAll;
        gfe_int_desc_type intDesc;
        gfe_rx_end_type rxStatus;
    } gfe_state_type;

endpackage

// File: hw/gfe_group_frame_event_control.sv
/*
 * group frame event control: message configuration copy from end of
 * message transmit descriptors, frame realign / frame loss interrupt
 * descriptor masking, and group wide receive abort on frame loss, with an
 * axi4-lite register slave and a sticky interrupt status.
 * assumes: one clock, all inputs synchronous to clk; the framer drives
 * frameLossCondition as a level and frameRealignEvent as a pulse.
 */
// Notes on behaviour
// - direct host message config writes always accepted
// - realign unmasked: emit realign interrupt descriptor
// - realign masked: suppress realign interrupt descriptor
// - loss unmasked: descriptor for loss or recovery
// - loss masked: receive errors reported as loss
// - abort off: receiver keeps processing during loss
// - abort on: all group channels abort on loss
// - abort on: hdlc channels resume after loss clears
// - abort on: transparent channels deactivated, host reactivates
`timescale 1ns/100ps
`include "gfe_consts.svh"

module gfe_group_frame_event_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire gfe_pkg::gfe_axi_req_type axiReq,
    output gfe_pkg::gfe_axi_resp_type axiResp,
    input wire logic frameRealignEvent,
    input wire logic frameLossCondition,
    input wire gfe_pkg::gfe_rx_end_type rxEnd,
    input wire gfe_pkg::gfe_tx_desc_type txDesc,
    input wire logic txMsgStart,
    output logic [`GFE_MSGCFG_W-1:0] txMsgCfg,
    output logic rxAbortAll,
    output logic rxSuspend,
    output logic [`GFE_NCHAN-1:0] chanActive,
    output gfe_pkg::gfe_int_desc_type intDesc,
    output gfe_pkg::gfe_rx_end_type rxStatus,
    output logic irq
);
    import gfe_pkg::*;

    gfe_state_type s_q; // registered state
    gfe_state_type s_d; // next state

    // byte lane merge for strobed writes
    // unstrobed lanes keep their old byte
    function automatic logic [31:0] laneMerge(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // writes answer one edge after both halves park,
    // reads on the same edge that takes the address
    logic wrGo; // both write halves held, no response pending
    logic [31:0] wrVal; // strobed value for the addressed register
    logic [31:0] oldVal; // current value of the addressed register
    logic [`GFE_STAT_W-1:0] clrBits; // write-one-to-clear bits this cycle
    logic [`GFE_STAT_W-1:0] evts; // events seen this cycle
    logic lossRise; // frame loss just began
    logic lossFall; // frame recovered
    logic rxErrSeen; // receiver ended a message in error
    gfe_rx_err_type rxCode; // error code after masking substitution
    logic [31:0] rdVal; // read decode

    // next state: bus slave, configuration, events, descriptors
    // one process, so each field has one driver
    always_comb begin
        s_d = s_q;
        wrVal = 32'h00000000;
        oldVal = 32'h00000000;
        clrBits = '0;
        rdVal = 32'h00000000;
        rxCode = ERR_NONE;
        // one-cycle pulses drop back every cycle
        s_d.rxAbortAll = 1'b0;
        s_d.intDesc = '0;
        s_d.rxStatus = '0;

        // write address and data are taken independently, in either order
        if (axiReq.awvalid && s_q.awRdy) begin
            s_d.awFull = 1'b1;
            s_d.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_q.wRdy) begin
            s_d.wFull = 1'b1;
            s_d.wData = axiReq.wdata;
            s_d.wStrb = axiReq.wstrb;
        end
        if (s_q.bValid && axiReq.bready) begin
            s_d.bValid = 1'b0;
        end

        // direct host message config write lands first so that a message
        // start in the same cycle still picks up a pending copy below
        wrGo = s_q.awFull && s_q.wFull && !s_q.bValid;
        if (wrGo) begin
            s_d.awFull = 1'b0;
            s_d.wFull = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = `GFE_RESP_OKAY;
            // address decode
            if (s_q.awAddr == `GFE_OFF_CFG) begin
                oldVal[`GFE_CFG_COPY_BIT] = s_q.msgCfgCopyEnable;
                oldVal[`GFE_CFG_RMASK_BIT] = s_q.frameRealignIrqMask;
                oldVal[`GFE_CFG_LMASK_BIT] = s_q.frameLossIrqMask;
                oldVal[`GFE_CFG_ABORT_BIT] = s_q.frameLossAbortEnable;
                wrVal = laneMerge(oldVal, s_q.wData, s_q.wStrb);
                // a zero here is unsupported; it simply stops the copy
                s_d.msgCfgCopyEnable = wrVal[`GFE_CFG_COPY_BIT];
                s_d.frameRealignIrqMask = wrVal[`GFE_CFG_RMASK_BIT];
                s_d.frameLossIrqMask = wrVal[`GFE_CFG_LMASK_BIT];
                s_d.frameLossAbortEnable = wrVal[`GFE_CFG_ABORT_BIT];
            end else if (s_q.awAddr == `GFE_OFF_MSGCFG) begin
                // accepted whatever the copy bit says
                oldVal[`GFE_MSGCFG_W-1:0] = s_q.msgCfg;
                wrVal = laneMerge(oldVal, s_q.wData, s_q.wStrb);
                s_d.msgCfg = wrVal[`GFE_MSGCFG_W-1:0];
            end else if (s_q.awAddr == `GFE_OFF_STAT) begin
                // read-only, write ignored
                s_d.bResp = `GFE_RESP_OKAY;
            end else if (s_q.awAddr == `GFE_OFF_CLR) begin
                wrVal = laneMerge(32'h00000000, s_q.wData, s_q.wStrb);
                clrBits = wrVal[`GFE_STAT_W-1:0];
            end else if (s_q.awAddr == `GFE_OFF_IEN) begin
                oldVal[`GFE_STAT_W-1:0] = s_q.irqEn;
                wrVal = laneMerge(oldVal, s_q.wData, s_q.wStrb);
                s_d.irqEn = wrVal[`GFE_STAT_W-1:0];
            end else if (s_q.awAddr == `GFE_OFF_TRANSP) begin
                s_d.chanTransp = laneMerge(s_q.chanTransp, s_q.wData,
                    s_q.wStrb);
            end else if (s_q.awAddr == `GFE_OFF_ACTIVE) begin
                // host (re)activation, overridden below by a loss abort
                s_d.chanActive = laneMerge(s_q.chanActive, s_q.wData,
                    s_q.wStrb);
            end else begin
                // unmapped offset
                s_d.bResp = `GFE_RESP_SLVERR;
            end
        end

        // read channel: answer on the same edge that takes the address
        if (s_q.rValid && axiReq.rready) begin
            s_d.rValid = 1'b0;
        end
        if (axiReq.arvalid && s_q.arRdy) begin
            s_d.rValid = 1'b1;
            s_d.rResp = `GFE_RESP_OKAY;
            if (axiReq.araddr == `GFE_OFF_CFG) begin
                rdVal[`GFE_CFG_COPY_BIT] = s_q.msgCfgCopyEnable;
                rdVal[`GFE_CFG_RMASK_BIT] = s_q.frameRealignIrqMask;
                rdVal[`GFE_CFG_LMASK_BIT] = s_q.frameLossIrqMask;
                rdVal[`GFE_CFG_ABORT_BIT] = s_q.frameLossAbortEnable;
            end else if (axiReq.araddr == `GFE_OFF_MSGCFG) begin
                rdVal[`GFE_MSGCFG_W-1:0] = s_q.msgCfg;
                rdVal[`GFE_MSGCFG_PEND_LSB +: `GFE_MSGCFG_W] = s_q.pendCfg;
                rdVal[`GFE_MSGCFG_PVAL_BIT] = s_q.pendValid;
            end else if (axiReq.araddr == `GFE_OFF_STAT) begin
                rdVal[`GFE_STAT_W-1:0] = s_q.stat;
            end else if (axiReq.araddr == `GFE_OFF_CLR) begin
                // write-only, reads as zero
                rdVal = 32'h00000000;
            end else if (axiReq.araddr == `GFE_OFF_IEN) begin
                rdVal[`GFE_STAT_W-1:0] = s_q.irqEn;
            end else if (axiReq.araddr == `GFE_OFF_TRANSP) begin
                rdVal = s_q.chanTransp;
            end else if (axiReq.araddr == `GFE_OFF_ACTIVE) begin
                rdVal = s_q.chanActive;
            end else begin
                s_d.rResp = `GFE_RESP_SLVERR;
            end
            s_d.rData = rdVal;
        end

        // transmit: copied config waits for the next message start, so a
        // message already on the wire keeps the config it started with
        if (txMsgStart && s_q.pendValid) begin
            s_d.msgCfg = s_q.pendCfg;
            s_d.pendValid = 1'b0;
        end
        // copy from the end of message descriptor only
        if (txDesc.valid && txDesc.endOfMessageFlag
            && s_q.msgCfgCopyEnable) begin
            s_d.pendCfg = txDesc.msgCfg;
            s_d.pendValid = 1'b1;
        end

        // frame loss edges from the level the framer holds
        // lossSeen resets low: loss held at release is a rise
        lossRise = frameLossCondition && !s_q.lossSeen;
        lossFall = !frameLossCondition && s_q.lossSeen;
        s_d.lossSeen = frameLossCondition;

        // abort enabled: group wide abort and transparent deactivation;
        // the deactivation wins over a host write in the same cycle
        if (lossRise && s_q.frameLossAbortEnable) begin
            s_d.rxAbortAll = 1'b1;
            s_d.chanActive = s_d.chanActive & ~s_q.chanTransp;
        end
        // hdlc receive held only while loss lasts, released on its own;
        // with abort off the receiver is never held
        s_d.rxSuspend = s_q.frameLossAbortEnable
            && frameLossCondition;

        // receive end status with loss substitution under the loss mask
        // a loss code from the receiver passes as is
        rxErrSeen = rxEnd.valid && (rxEnd.code != ERR_NONE);
        rxCode = rxEnd.code;
        if (s_q.frameLossIrqMask && ((rxEnd.code == ERR_ABORT)
            || (rxEnd.code == ERR_CHECKSUM) || (rxEnd.code == ERR_LENGTH)
            || (rxEnd.code == ERR_ALIGN))) begin
            rxCode = ERR_FRAME_LOSS;
        end
        if (rxEnd.valid) begin
            s_d.rxStatus.valid = 1'b1;
            s_d.rxStatus.chan = rxEnd.chan;
            s_d.rxStatus.code = rxCode;
        end

        // interrupt descriptor: one per cycle, realign first, then loss or
        // recovery, then receive error; the sticky status keeps the rest
        // only receive errors carry a channel
        if (frameRealignEvent && !s_q.frameRealignIrqMask) begin
            s_d.intDesc.valid = 1'b1;
            s_d.intDesc.evt = EVT_REALIGN;
        end else if ((lossRise || lossFall) && !s_q.frameLossIrqMask) begin
            s_d.intDesc.valid = 1'b1;
            s_d.intDesc.evt = lossRise ? EVT_FRAME_LOSS
                : EVT_FRAME_RECOVERY;
        end else if (rxErrSeen) begin
            s_d.intDesc.valid = 1'b1;
            s_d.intDesc.evt = EVT_RX_ERROR;
            s_d.intDesc.err = rxCode;
            s_d.intDesc.chan = rxEnd.chan;
        end

        // sticky status: a set in the clearing cycle survives
        evts = '0;
        evts[`GFE_ST_REALIGN] = frameRealignEvent;
        evts[`GFE_ST_LOSS] = lossRise;
        evts[`GFE_ST_RECOVER] = lossFall;
        evts[`GFE_ST_RXERR] = rxErrSeen;
        s_d.stat = (s_q.stat & ~clrBits) | evts;
        s_d.irq = |(s_d.stat & s_d.irqEn);

        // write readies held low while their half is parked, read ready while a read answer waits
        s_d.awRdy = !s_d.awFull;
        s_d.wRdy = !s_d.wFull;
        s_d.arRdy = !s_d.rValid;
    end

    // state register, synchronous reset to constants
    // rest clears to zero, parked bus halves too
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.msgCfgCopyEnable <= `GFE_RST_COPY;
            s_q.frameRealignIrqMask <= `GFE_RST_RMASK;
            s_q.frameLossIrqMask <= `GFE_RST_LMASK;
            s_q.frameLossAbortEnable <= `GFE_RST_ABORT;
            s_q.msgCfg <= `GFE_RST_MSGCFG;
            s_q.irqEn <= `GFE_RST_IEN;
            s_q.chanTransp <= `GFE_RST_TRANSP;
            s_q.chanActive <= `GFE_RST_ACTIVE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    // no logic at the pins, so no glitches
    assign axiResp.awready = s_q.awRdy;
    assign axiResp.wready = s_q.wRdy;
    assign axiResp.bvalid = s_q.bValid;
    assign axiResp.bresp = s_q.bResp;
    assign axiResp.arready = s_q.arRdy;
    assign axiResp.rvalid = s_q.rValid;
    assign axiResp.rdata = s_q.rData;
    assign axiResp.rresp = s_q.rResp;
    assign txMsgCfg = s_q.msgCfg;
    assign rxAbortAll = s_q.rxAbortAll;
    assign rxSuspend = s_q.rxSuspend;
    assign chanActive = s_q.chanActive;
    assign intDesc = s_q.intDesc;
    assign rxStatus = s_q.rxStatus;
    assign irq = s_q.irq;

endmodule // gfe_group_frame_event_control

// File: verif/gfe_checker.sv
/*
 * port-level assertions for the group frame event control block.
 * assumes: bound from the testbench top file; one clock, rst_n sync low.
 */
`timescale 1ns/100ps
`include "gfe_consts.svh"

module gfe_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire gfe_pkg::gfe_axi_resp_type axiResp,
    input wire logic frameRealignEvent,
    input wire logic frameLossCondition,
    input wire gfe_pkg::gfe_rx_end_type rxEnd,
    input wire logic txMsgStart,
    input wire logic [`GFE_MSGCFG_W-1:0] txMsgCfg,
    input wire logic rxAbortAll,
    input wire logic rxSuspend,
    input wire gfe_pkg::gfe_int_desc_type intDesc,
    input wire gfe_pkg::gfe_rx_end_type rxStatus
);
    import gfe_pkg::*;

    // single domain, so clock and reset are stated once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    realign_desc_a: assert property (
        intDesc.valid && intDesc.evt == EVT_REALIGN
        |-> $past(frameRealignEvent))
        else $error("realign descriptor without a realign event");
    loss_desc_a: assert property (
        intDesc.valid && intDesc.evt == EVT_FRAME_LOSS
        |-> $past(frameLossCondition) && !$past(frameLossCondition, 2))
        else $error("frame loss descriptor without a loss rise");
    recover_desc_a: assert property (
        intDesc.valid && intDesc.evt == EVT_FRAME_RECOVERY
        |-> !$past(frameLossCondition) && $past(frameLossCondition, 2))
        else $error("recovery descriptor without a loss fall");
    abort_cause_a: assert property (
        rxAbortAll
        |-> $past(frameLossCondition) && !$past(frameLossCondition, 2))
        else $error("group abort without a loss rise");
    abort_hold_a: assert property (
        rxAbortAll |-> rxSuspend ##1 !rxAbortAll)
        else $error("group abort not a single pulse with suspend");
    suspend_lag_a: assert property (
        rxSuspend |-> $past(frameLossCondition))
        else $error("receive still held after loss cleared");
    rx_status_a: assert property (
        rxEnd.valid |=> rxStatus.valid && rxStatus.chan == $past(rxEnd.chan)
        && (rxStatus.code == $past(rxEnd.code)
        || rxStatus.code == ERR_FRAME_LOSS))
        else $error("receive status wrong channel or code");
    rx_clean_a: assert property (
        rxEnd.valid && rxEnd.code == ERR_NONE |=> rxStatus.code == ERR_NONE)
        else $error("clean message reported with an error");
    tx_cfg_hold_a: assert property (
        $changed(txMsgCfg) |-> $past(txMsgStart) || $rose(axiResp.bvalid))
        else $error("message config changed outside a message start");

endmodule // gfe_checker

// File: verif/gfe_framer_model.sv
/*
 * framer and transmit/receive engine model driving the event side.
 * assumes: tasks called from the testbench top; clk shared with the dut.
 */
`timescale 1ns/100ps

module gfe_framer_model (
    input wire logic clk,
    output logic frameRealignEvent,
    output logic frameLossCondition,
    output gfe_pkg::gfe_rx_end_type rxEnd,
    output gfe_pkg::gfe_tx_desc_type txDesc,
    output logic txMsgStart
);
    import gfe_pkg::*;

    // quiet at time zero, framing in lock
    initial begin
        frameRealignEvent = 1'b0;
        frameLossCondition = 1'b0;
        rxEnd = '0;
        txDesc = '0;
        txMsgStart = 1'b0;
    end

    // one-cycle alignment change pulse
    task automatic realign;
        @(posedge clk);
        frameRealignEvent <= 1'b1;
        @(posedge clk);
        frameRealignEvent <= 1'b0;
    endtask

    // loss is a level, held until told otherwise
    task automatic loss(input logic v);
        @(posedge clk);
        frameLossCondition <= v;
    endtask

    // payload scrambled once invalid so stale fields cannot pass
    task automatic msgEnd(input logic [4:0] c, input gfe_rx_err_type e);
        @(posedge clk);
        rxEnd <= '{1'b1, c, e};
        @(posedge clk);
        rxEnd <= '{1'b0, ~c, gfe_rx_err_type'(~e)};
    endtask

    // descriptor fetch, same scrambling after release
    task automatic desc(input logic end_of_message_flag, input logic [7:0] m);
        @(posedge clk);
        txDesc <= '{1'b1, end_of_message_flag, m};
        @(posedge clk);
        txDesc <= '{1'b0, ~end_of_message_flag, ~m};
    endtask

    // first cycle of the next transmit message
    task automatic start;
        @(posedge clk);
        txMsgStart <= 1'b1;
        @(posedge clk);
        txMsgStart <= 1'b0;
    endtask

endmodule // gfe_framer_model

// File: verif/gfe_group_frame_event_control_tb_top.sv
/*
 * self-checking bench: axi4-lite register tasks plus framer model calls.
 * assumes: package, consts header, checker and framer model compiled.
 */
`timescale 1ns/100ps
`include "gfe_consts.svh"

module gfe_group_frame_event_control_tb_top;
    import gfe_pkg::*;

    logic clk;
    logic rst_n;
    gfe_axi_req_type axiReq;
    gfe_axi_resp_type axiResp;
    logic frameRealignEvent, frameLossCondition, txMsgStart;
    gfe_rx_end_type rxEnd, rxStatus;
    gfe_tx_desc_type txDesc;
    logic [`GFE_MSGCFG_W-1:0] txMsgCfg;
    logic rxAbortAll, rxSuspend, irq;
    logic [`GFE_NCHAN-1:0] chanActive;
    gfe_int_desc_type intDesc;
    int errTotal, nTests, nDesc, nAbt;
    gfe_evt_type lastEvt;
    gfe_rx_err_type lastCode, lastErr;
    logic [31:0] rv; // last read data
    logic [1:0] rr; // last response code
    logic [4:0] lastChan;

    gfe_group_frame_event_control dut (.clk(clk), .rst_n(rst_n),
        .axiReq(axiReq), .axiResp(axiResp),
        .frameRealignEvent(frameRealignEvent),
        .frameLossCondition(frameLossCondition), .rxEnd(rxEnd),
        .txDesc(txDesc), .txMsgStart(txMsgStart), .txMsgCfg(txMsgCfg),
        .rxAbortAll(rxAbortAll), .rxSuspend(rxSuspend),
        .chanActive(chanActive), .intDesc(intDesc), .rxStatus(rxStatus),
        .irq(irq));

    gfe_framer_model fm (.clk(clk), .frameRealignEvent(frameRealignEvent),
        .frameLossCondition(frameLossCondition), .rxEnd(rxEnd),
        .txDesc(txDesc), .txMsgStart(txMsgStart));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pulses watched at the falling edge, clear of update races
    always @(negedge clk) begin
        if (intDesc.valid === 1'b1) begin
            nDesc++;
            lastEvt = intDesc.evt;
            lastErr = intDesc.err;
            lastChan = intDesc.chan;
        end
        if (rxAbortAll === 1'b1) nAbt++;
        if (rxStatus.valid === 1'b1) lastCode = rxStatus.code;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nTests++;
        if (g !== e) begin
            errTotal++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    // look at the falling edge, act just after the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hF);
        logic aT, wT, bT;
        @(posedge clk);
        axiReq <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d,
            wstrb:s, bready:1'b1, default:'0};
        bT = 1'b0;
        while (!bT) begin
            @(negedge clk);
            aT = axiReq.awvalid && axiResp.awready === 1'b1;
            wT = axiReq.wvalid && axiResp.wready === 1'b1;
            bT = axiResp.bvalid === 1'b1;
            rr = axiResp.bresp;
            @(posedge clk);
            if (aT) axiReq.awvalid <= 1'b0;
            if (wT) axiReq.wvalid <= 1'b0;
        end
        axiReq.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic aT, rT;
        @(posedge clk);
        axiReq <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
        rT = 1'b0;
        while (!rT) begin
            @(negedge clk);
            aT = axiReq.arvalid && axiResp.arready === 1'b1;
            rT = axiResp.rvalid === 1'b1;
            rv = axiResp.rdata;
            rr = axiResp.rresp;
            @(posedge clk);
            if (aT) axiReq.arvalid <= 1'b0;
        end
        axiReq.rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rv, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic done(input string s);
        $display("test %s ended, %0d mismatches so far", s, errTotal);
    endtask

    task automatic closeOut;
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // whole run is under two hundred cycles; this cuts off a hang
    initial begin
        #200000;
        errTotal++;
        $display("BAD %0t watchdog expired", $time);
        closeOut();
    end

    initial begin
        axiReq = '0;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        rdc(`GFE_OFF_CFG, 32'h00000040);
        rdc(`GFE_OFF_IEN, 32'h00000000);
        rdc(`GFE_OFF_ACTIVE, 32'h00000000);
        rd(8'h1C);
        chk(rr, `GFE_RESP_SLVERR);
        wr(8'h1C, 32'h00000000);
        chk(rr, `GFE_RESP_SLVERR);
        done("reset");
        wr(`GFE_OFF_CLR, 32'h0000000F);
        wr(`GFE_OFF_IEN, 32'h00000001);
        fm.realign();
        cyc(2);
        chk(nDesc, 1);
        chk(lastEvt, EVT_REALIGN);
        chk(irq, 1'b1);
        wr(`GFE_OFF_IEN, 32'h00000000);
        cyc(2);
        chk(irq, 1'b0);
        wr(`GFE_OFF_IEN, 32'h00000001);
        wr(`GFE_OFF_CLR, 32'h00000001);
        cyc(2);
        chk(irq, 1'b0);
        rdc(`GFE_OFF_STAT, 32'h00000000);
        wr(`GFE_OFF_CFG, 32'h00000060);
        fm.realign();
        cyc(2);
        chk(nDesc, 1);
        done("realign");
        wr(`GFE_OFF_CFG, 32'h00000040);
        fm.loss(1'b1);
        cyc(3);
        chk(lastEvt, EVT_FRAME_LOSS);
        chk(rxSuspend, 1'b0);
        fm.msgEnd(5'h03, ERR_CHECKSUM);
        cyc(2);
        chk(lastCode, ERR_CHECKSUM);
        fm.loss(1'b0);
        cyc(3);
        chk(nDesc, 4);
        chk(lastEvt, EVT_FRAME_RECOVERY);
        chk(nAbt, 0);
        done("loss");
        wr(`GFE_OFF_CFG, 32'h00000050);
        for (int i = 1; i <= 4; i++) begin
            fm.msgEnd(5'h07, gfe_rx_err_type'(i));
            cyc(2);
            chk(lastCode, ERR_FRAME_LOSS);
            chk(lastErr, ERR_FRAME_LOSS);
            chk(lastChan, 5'h07);
        end
        fm.msgEnd(5'h07, ERR_NONE);
        fm.loss(1'b1);
        cyc(2);
        fm.loss(1'b0);
        cyc(3);
        chk(lastCode, ERR_NONE);
        chk(nDesc, 8);
        done("mask");
        wr(`GFE_OFF_CFG, 32'h00000048);
        wr(`GFE_OFF_TRANSP, 32'h00000001);
        wr(`GFE_OFF_ACTIVE, 32'h00000003);
        fm.loss(1'b1);
        cyc(3);
        chk(nAbt, 1);
        chk(rxSuspend, 1'b1);
        chk(chanActive, 32'h00000002);
        fm.loss(1'b0);
        cyc(3);
        chk(rxSuspend, 1'b0);
        wr(`GFE_OFF_ACTIVE, 32'h00000003);
        rdc(`GFE_OFF_ACTIVE, 32'h00000003);
        wr(`GFE_OFF_TRANSP, 32'h0000FF00, 4'h2);
        rdc(`GFE_OFF_TRANSP, 32'h0000FF01);
        done("abort");
        wr(`GFE_OFF_CFG, 32'h00000040);
        fm.desc(1'b1, 8'hA5);
        cyc(2);
        chk(txMsgCfg, 8'h00);
        rdc(`GFE_OFF_MSGCFG, 32'h0001A500);
        fm.start();
        cyc(2);
        chk(txMsgCfg, 8'hA5);
        fm.desc(1'b0, 8'h11);
        fm.start();
        cyc(2);
        chk(txMsgCfg, 8'hA5);
        wr(`GFE_OFF_MSGCFG, 32'h0000003C);
        cyc(1);
        chk(txMsgCfg, 8'h3C);
        done("copy");
        closeOut();
    end

endmodule // gfe_group_frame_event_control_tb_top

bind gfe_group_frame_event_control gfe_checker chk_i (.clk(clk),
    .rst_n(rst_n), .axiResp(axiResp), .frameRealignEvent(frameRealignEvent),
    .frameLossCondition(frameLossCondition), .rxEnd(rxEnd),
    .txMsgStart(txMsgStart), .txMsgCfg(txMsgCfg), .rxAbortAll(rxAbortAll),
    .rxSuspend(rxSuspend), .intDesc(intDesc), .rxStatus(rxStatus));
